// >>> hw/sstw_regs.vh
/*
 * register map and timing constants of the three/two-wire synchronous serial block.
 * assumes: included by the design file, the checker and the bench, by bare name.
 */
`ifndef SSTW_REGS_VH
`define SSTW_REGS_VH

`define SSTW_ADDR_MODE_CTRL   16'hffaa
`define SSTW_ADDR_WIRE_SEL    16'hffab
`define SSTW_ADDR_SHIFT       16'hffa9
`define SSTW_MODE_RESET       8'h00
`define SSTW_WIRE_RESET       8'h00
`define SSTW_SHIFT_RESET      8'h00
`define SSTW_BIT_ENABLE       7
`define SSTW_BIT_DIR          2
`define SSTW_BIT_CLK_HI       1
`define SSTW_BIT_CLK_LO       0
`define SSTW_BIT_WIRE         0
`define SSTW_MODE_MASK        8'h87
`define SSTW_CLK_EXT          2'b00
`define SSTW_CLK_TIMER        2'b01
`define SSTW_CLK_DIV8         2'b10
`define SSTW_CLK_DIV128       2'b11
`define SSTW_DIV8_HALF        7'h03
`define SSTW_DIV128_HALF      7'h3f
`define SSTW_BITS_PER_XFER    4'h8

`endif

// >>> hw/sstw_serial.v
/*
 * three-wire / two-wire clock-synchronous 8-bit serial interface, device side.
 * assumes: cpu bus is a simple synchronous sfr port on ref_clk_i with byte and
 * single-bit writes; pins and the external/timer clock come from outside the
 * domain and are synchronised here; port muxing sits outside, steered by the
 * *_serial_o ownership outputs.
 * limitations: an external clock must hold each level for at least four
 * ref_clk_i cycles, since its edges are seen through a two-flop synchroniser;
 * disabling mid-transfer abandons the frame without setting the done flag;
 * the done flag is cleared only by the next start, not by software;
 * the out line changes only after a falling serial clock edge, so a far end
 * that samples on the rising edge always sees a settled bit;
 * a shift register write while stopped is stored but never starts a frame.
 */
// Summary of operation
// - enable 0 stops shifting, clears bit counter
// - disabled: all three pins back to port
// - enabled: unused input/output pin stays port
// - dir 0 starts on write, 1 on read
// - three-wire receive-only holds serial out low
// - clock select: ext, timer, div8, div128
// - three-wire: clock, out, in lines
// - two-wire: clock plus one shared data line
// - wire select 0 three-wire, 1 two-wire
// - reset clears mode and wire registers
// - mode register byte or single-bit writable
// - eight bits per transfer, msb first
// - shift out on fall, sample on rise
// - stop after eighth bit, set done flag
// - shift write while disabled never starts transfer
`timescale 1ns/1ps
`include "sstw_regs.vh"

module sstw_serial (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rstn_i,
    // cpu register port
    input  wire [15:0] addr_i,
    input  wire        wr_i,
    input  wire        bit_wr_i,
    input  wire [2:0]  bit_sel_i,
    input  wire [7:0]  wdata_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // transfer status
    output reg         xfer_done_o,
    output reg         busy_o,
    // serial pins
    input  wire        sclk_pin_i,
    output reg         sclk_pin_o,
    output reg         sclk_pin_oe_o,
    input  wire        sdata_in_pin_i,
    output reg         sdata_out_pin_o,
    output reg         sdata_out_pin_oe_o,
    input  wire        timer_clk_i,
    // pin ownership towards the port mux
    output reg         sclk_serial_o,
    output reg         sin_serial_o,
    output reg         sout_serial_o
);

    // one-hot transfer states; HIGH and LOW follow the serial clock level
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOW  = 3'b010;
    localparam [2:0] ST_HIGH = 3'b100;

    reg  [7:0] mode_q;
    reg        wire_q;
    reg  [7:0] shift_q;
    reg  [3:0] cnt_q;
    reg  [2:0] st_q;
    reg  [6:0] div_q;
    reg        xfer_done_q;
    reg  [1:0] sck_s_q;
    reg  [1:0] sdi_s_q;
    reg  [1:0] tmr_s_q;
    reg        sck_prev_q;
    reg        tmr_prev_q;
    reg        out_bit_q;
    reg  [7:0] shift_d;
    reg  [3:0] cnt_d;
    reg  [2:0] st_d;
    reg  [6:0] div_d;
    reg        done_d;
    reg        out_bit_d;
    reg        wire_d;
    wire [7:0] mode_d;
    wire [7:0] mode_mask  = `SSTW_MODE_MASK;
    wire [7:0] wire_reset = `SSTW_WIRE_RESET;

    wire       en      = mode_q[`SSTW_BIT_ENABLE];
    wire       dir_rx  = mode_q[`SSTW_BIT_DIR];
    wire [1:0] clk_sel = {mode_q[`SSTW_BIT_CLK_HI], mode_q[`SSTW_BIT_CLK_LO]};
    wire       ext_clk = (clk_sel == `SSTW_CLK_EXT);
    wire       sel_mode  = (addr_i == `SSTW_ADDR_MODE_CTRL);
    wire       sel_wire  = (addr_i == `SSTW_ADDR_WIRE_SEL);
    wire       sel_shift = (addr_i == `SSTW_ADDR_SHIFT);
    // a write while disabled only loads data; no start is remembered
    wire       start = en && (st_q == ST_IDLE) && sel_shift &&
                       ((wr_i && !dir_rx) || (rd_i && dir_rx));
    wire [6:0] half_lim = (clk_sel == `SSTW_CLK_DIV8) ? `SSTW_DIV8_HALF
                                                       : `SSTW_DIV128_HALF;
    reg        tick;
    reg        ext_fall;
    reg        ext_rise;

    // clock source: internal sources yield half-period ticks, external gives edges
    always @* begin
        ext_fall = sck_prev_q && !sck_s_q[1];
        ext_rise = !sck_prev_q && sck_s_q[1];
        case (clk_sel)
            `SSTW_CLK_TIMER: tick = tmr_s_q[1] && !tmr_prev_q;
            `SSTW_CLK_DIV8:  tick = (div_q == half_lim);
            `SSTW_CLK_DIV128: tick = (div_q == half_lim);
            default:         tick = 1'b0;
        endcase
    end

    wire fall_ev = ext_clk ? ext_fall : (tick && st_q == ST_HIGH);
    wire rise_ev = ext_clk ? ext_rise : (tick && st_q == ST_LOW);

    // two-flop synchronisers: every pin and the timer output cross in here
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            sck_s_q    <= 2'b11;
            sdi_s_q    <= 2'b00;
            tmr_s_q    <= 2'b00;
            sck_prev_q <= 1'b1;
            tmr_prev_q <= 1'b0;
        end else begin
            sck_s_q    <= {sck_s_q[0], sclk_pin_i};
            sdi_s_q    <= {sdi_s_q[0], sdata_in_pin_i};
            tmr_s_q    <= {tmr_s_q[0], timer_clk_i};
            sck_prev_q <= sck_s_q[1];
            tmr_prev_q <= tmr_s_q[1];
        end
    end

    // mode register next value per bit; masked bits stay zero whatever is written
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_mode_bit
            localparam [2:0] BIT_IDX = gi;
            wire byte_wr   = sel_mode && wr_i;
            wire single_wr = sel_mode && bit_wr_i && (bit_sel_i == BIT_IDX);
            assign mode_d[gi] = mode_mask[gi] &
                                (byte_wr ? wdata_i[gi] : (single_wr ? wdata_i[0] : mode_q[gi]));
        end
    endgenerate

    always @* begin
        wire_d = wire_q;
        if (sel_wire && wr_i)
            wire_d = wdata_i[`SSTW_BIT_WIRE];
        else if (sel_wire && bit_wr_i && bit_sel_i == 3'd0)
            wire_d = wdata_i[0];
    end

    // register writes
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mode_q <= `SSTW_MODE_RESET;
            wire_q <= wire_reset[`SSTW_BIT_WIRE];
        end else begin
            mode_q <= mode_d;
            wire_q <= wire_d;
        end
    end

    // transfer engine, next-state logic
    always @* begin
        shift_d   = shift_q;
        cnt_d     = cnt_q;
        st_d      = st_q;
        div_d     = div_q;
        done_d    = xfer_done_q;
        out_bit_d = out_bit_q;
        if (!en) begin
            cnt_d = 4'h0;
            st_d  = ST_IDLE;
            div_d = 7'h00;
            // stopped: a shift write stores data and nothing else
            if (sel_shift && wr_i)
                shift_d = wdata_i;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    div_d = 7'h00;
                    if (sel_shift && wr_i && !dir_rx)
                        shift_d = wdata_i;
                    if (start) begin
                        done_d = 1'b0;
                        cnt_d  = 4'h0;
                        st_d   = ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    div_d = (tick || ext_clk) ? 7'h00 : div_q + 7'h01;
                    if (fall_ev) begin
                        // the line only changes on a falling edge
                        out_bit_d = shift_q[7];
                        st_d      = ST_LOW;
                    end
                end
                ST_LOW: begin
                    div_d = (tick || ext_clk) ? 7'h00 : div_q + 7'h01;
                    if (rise_ev) begin
                        // both modes sample the input pin; two-wire relies on the shared line reaching it
                        shift_d = {shift_q[6:0], sdi_s_q[1]};
                        cnt_d   = cnt_q + 4'h1;
                        if (cnt_q == `SSTW_BITS_PER_XFER - 4'h1) begin
                            st_d   = ST_IDLE;
                            done_d = 1'b1;
                        end else begin
                            st_d = ST_HIGH;
                        end
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    // transfer engine registers
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            shift_q     <= `SSTW_SHIFT_RESET;
            cnt_q       <= 4'h0;
            st_q        <= ST_IDLE;
            div_q       <= 7'h00;
            xfer_done_q <= 1'b0;
            out_bit_q   <= 1'b0;
        end else begin
            shift_q     <= shift_d;
            cnt_q       <= cnt_d;
            st_q        <= st_d;
            div_q       <= div_d;
            xfer_done_q <= done_d;
            out_bit_q   <= out_bit_d;
        end
    end

    // read data and pin drive next values
    reg  [7:0] rdata_d;
    reg        sclk_d;
    reg        sclk_oe_d;
    reg        sclk_own_d;
    reg        sout_d;
    reg        sout_oe_d;
    reg        sout_own_d;
    reg        sin_own_d;

    always @* begin
        case (addr_i)
            `SSTW_ADDR_MODE_CTRL: rdata_d = mode_q;
            `SSTW_ADDR_WIRE_SEL:  rdata_d = {7'h00, wire_q};
            `SSTW_ADDR_SHIFT:     rdata_d = shift_q;
            default:              rdata_d = 8'h00;
        endcase
        // internal clock idles high between transfers
        sclk_d     = (st_q != ST_LOW);
        sclk_oe_d  = en && !ext_clk;
        sclk_own_d = en;
        // three-wire receive-only pins the out line low; else the fall latch
        sout_d     = (dir_rx && !wire_q) ? 1'b0 : out_bit_q;
        // two-wire: the out pin is the shared line, driven only to transmit
        sout_oe_d  = en && !dir_rx;
        sout_own_d = en && (wire_q || !dir_rx);
        // three-wire uses the input pin in both directions, two-wire never
        sin_own_d  = en && !wire_q;
    end

    // registered outputs
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rdata_o            <= 8'h00;
            xfer_done_o        <= 1'b0;
            busy_o             <= 1'b0;
            sclk_pin_o         <= 1'b1;
            sclk_pin_oe_o      <= 1'b0;
            sdata_out_pin_o    <= 1'b0;
            sdata_out_pin_oe_o <= 1'b0;
            sclk_serial_o      <= 1'b0;
            sin_serial_o       <= 1'b0;
            sout_serial_o      <= 1'b0;
        end else begin
            rdata_o            <= rdata_d;
            xfer_done_o        <= xfer_done_q;
            busy_o             <= (st_q != ST_IDLE);
            sclk_pin_o         <= sclk_d;
            sclk_pin_oe_o      <= sclk_oe_d;
            sclk_serial_o      <= sclk_own_d;
            sdata_out_pin_o    <= sout_d;
            sdata_out_pin_oe_o <= sout_oe_d;
            sout_serial_o      <= sout_own_d;
            sin_serial_o       <= sin_own_d;
        end
    end

endmodule // sstw_serial

// >>> sim/sstw_peer.sv
/* far-end clock-synchronous peripheral: puts a bit out on each clock fall,
   takes one in on each rise; assumes the clock idles high between frames. */
`timescale 1ns/1ps
module sstw_peer (
    // serial lines
    input  wire       sclk_i,
    input  wire       sdo_i,
    output reg        sdi_o,
    // byte to send, load strobe, byte received
    input  wire [7:0] tx_i,
    input  wire       load_i,
    output reg  [7:0] rx_o
);
    reg [7:0] sh_q;
    initial sdi_o = 1'b0;
    initial rx_o = 8'h00;
    always @(posedge load_i)
        sh_q = tx_i;
    // msb first; refill with inverted bits so a stale level never looks valid
    always @(negedge sclk_i) begin
        sdi_o <= sh_q[7];
        sh_q  <= {sh_q[6:0], ~sh_q[7]};
    end
    always @(posedge sclk_i)
        rx_o <= {rx_o[6:0], sdo_i};
endmodule // sstw_peer

// >>> sim/sstw_serial_assertions.sv
/* checker for the serial block, bound to its top module.
   assumes the register map of sstw_regs.vh and one clock domain. */
`timescale 1ns/1ps
`include "sstw_regs.vh"
module sstw_serial_chk (
    // clock, reset and strobes
    input wire        ref_clk_i, rstn_i, wr_i, bit_wr_i, rd_i,
    // cpu data
    input wire [15:0] addr_i,
    input wire [2:0]  bit_sel_i,
    input wire [7:0]  wdata_i, rdata_o,
    // status and pins
    input wire        xfer_done_o, busy_o, sclk_pin_o, sclk_pin_oe_o,
    input wire        sdata_out_pin_o, sdata_out_pin_oe_o,
    input wire        sclk_serial_o, sin_serial_o, sout_serial_o
);
    localparam [15:0] MC = `SSTW_ADDR_MODE_CTRL;
    localparam [15:0] SR = `SSTW_ADDR_SHIFT;
    reg  [7:0] mode_q;
    reg  [3:0] fall_q;
    // shadow of the mode register so start and stop can be judged
    wire       start = addr_i == SR && mode_q[7] && !busy_o && (mode_q[2] ? rd_i : wr_i);
    always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mode_q <= 8'h00;
            fall_q <= 4'h0;
        end else begin
            if (wr_i && addr_i == MC)
                mode_q <= wdata_i;
            else if (bit_wr_i && addr_i == MC)
                mode_q[bit_sel_i] <= wdata_i[0];
            fall_q <= ($rose(busy_o) ? 4'h0 : fall_q) + {3'h0, $fell(sclk_pin_o)};
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    reset_vals_a: assert property (disable iff (1'b0)
        !rstn_i |=> sclk_pin_o && !busy_o && !xfer_done_o) else $error("bad reset values");
    start_lat_a: assert property (start |-> ##2 busy_o) else $error("no start");
    stop_idle_a: assert property (
        !mode_q[7] && !$past(mode_q[7]) && !$past(mode_q[7], 2) |-> !busy_o && !sclk_serial_o
        && !sin_serial_o && !sout_serial_o) else $error("active while stopped");
    done_flag_a: assert property ($fell(busy_o) |-> xfer_done_o) else $error("no done");
    clk_idle_a: assert property (!busy_o && !$past(busy_o) |-> sclk_pin_o)
        else $error("clock not high");
    eight_bits_a: assert property ($fell(busy_o) && sclk_pin_oe_o |-> fall_q == 4'h8)
        else $error("bit count");
    rise_stable_a: assert property (busy_o && $rose(sclk_pin_o) |-> $stable(sdata_out_pin_o))
        else $error("data moved on rise");
    rx_quiet_a: assert property (
        busy_o && mode_q[2] |-> !(sdata_out_pin_o && sdata_out_pin_oe_o)) else $error("rx drive");
    mode_read_a: assert property (
        addr_i == MC && !wr_i && !bit_wr_i |=> rdata_o == (mode_q & `SSTW_MODE_MASK))
        else $error("mode readback");
    cover property ($fell(busy_o));
    cover property (start && mode_q[2]);
    cover property (busy_o && sdata_out_pin_oe_o && !mode_q[2]);
endmodule // sstw_serial_chk
bind sstw_serial sstw_serial_chk u_chk (.*);

// >>> sim/testbench.sv
/* self-checking bench of the serial block with a far-end peer model.
   assumes hw/ on the include path. */
`timescale 1ns/1ps
`include "sstw_regs.vh"
module testbench;
    localparam [15:0] MC = `SSTW_ADDR_MODE_CTRL;
    localparam [15:0] WS = `SSTW_ADDR_WIRE_SEL;
    localparam [15:0] SR = `SSTW_ADDR_SHIFT;
    reg         ref_clk_i = 0, rstn_i = 0, wr_i = 0, bit_wr_i = 0, rd_i = 0;
    reg         timer_clk_i = 0, ext_q = 1, wire_q = 0, p_ld = 0;
    reg  [15:0] addr_i = 16'h0000;
    reg  [2:0]  bit_sel_i = 3'h0;
    reg  [7:0]  wdata_i = 8'h00, p_tx = 8'h00, rd_q;
    wire [7:0]  rdata_o, p_rx;
    wire        xfer_done_o, busy_o, sclk_pin_o, sclk_pin_oe_o, sdata_out_pin_o, p_sdi;
    wire        sdata_out_pin_oe_o, sclk_serial_o, sin_serial_o, sout_serial_o;
    wire        sclk_pin_i = sclk_pin_oe_o ? sclk_pin_o : ext_q;
    wire        sd_line = sdata_out_pin_oe_o ? sdata_out_pin_o : p_sdi;
    wire        sdata_in_pin_i = wire_q ? sd_line : p_sdi;
    integer     mismatches = 0, checked = 0, i;
    always #2 ref_clk_i = ~ref_clk_i;
    always #12 timer_clk_i = ~timer_clk_i;
    sstw_serial u_dut (.*);
    sstw_peer u_peer (.sclk_i(sclk_pin_i), .sdo_i(sd_line), .sdi_o(p_sdi), .tx_i(p_tx),
                      .load_i(p_ld), .rx_o(p_rx));
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one cpu cycle; read data is taken at the following falling edge
    task acc(input [15:0] a, input w, input b, input r, input [7:0] d);
        begin
            @(negedge ref_clk_i);
            {addr_i, wr_i, bit_wr_i, rd_i, wdata_i} = {a, w, b, r, d};
            @(negedge ref_clk_i);
            {wr_i, bit_wr_i, rd_i} = 3'b000;
            rd_q = rdata_o;
        end
    endtask
    task run(input [7:0] m, input w, input [7:0] tx, input [7:0] ptx);
        integer n;
        reg     any_oe, any_out;
        begin
            wire_q = w;
            acc(WS, 1, 0, 0, {7'h00, w});
            acc(MC, 1, 0, 0, m);
            p_tx = ptx;
            p_ld = 1;
            acc(SR, !m[2], 0, m[2], tx);
            p_ld = 0;
            any_oe = 0;
            any_out = 0;
            for (n = 0; n < 3000 && (n < 4 || busy_o); n = n + 1) begin
                @(negedge ref_clk_i);
                if (m[1:0] == `SSTW_CLK_EXT && n % 8 == 7)
                    ext_q = ~ext_q;
                any_oe = any_oe | (busy_o & sdata_out_pin_oe_o);
                any_out = any_out | (busy_o & sdata_out_pin_o);
            end
            if (n == 3000) begin
                mismatches = mismatches + 1;
                results;
            end
            cmp({6'h00, xfer_done_o, sclk_pin_o}, 8'h03);
            if (!m[2]) cmp(p_rx, tx);
            if (w) cmp({7'h00, any_oe}, {7'h00, !m[2]});
            if (!w && m[2]) cmp({7'h00, any_out}, 8'h00);
            if (!w) cmp({5'h00, sclk_serial_o, sin_serial_o, sout_serial_o}, {7'h03, !m[2]});
            acc(MC, 1, 0, 0, m & 8'hfb);
            acc(SR, 0, 0, 1, 8'h00);
            cmp(rd_q, ptx);
        end
    endtask
    task t_reset;
        begin
            acc(MC, 0, 0, 1, 8'h00);
            cmp(rd_q, `SSTW_MODE_RESET);
            acc(WS, 0, 0, 1, 8'h00);
            cmp(rd_q, `SSTW_WIRE_RESET);
            cmp({3'h0, sclk_pin_o, sclk_serial_o, sin_serial_o, sout_serial_o, busy_o}, 8'h10);
            $display("test reset done");
        end
    endtask
    task t_bits;
        begin
            acc(MC, 1, 0, 0, 8'hff);
            acc(MC, 0, 0, 1, 8'h00);
            cmp(rd_q, 8'h87);
            bit_sel_i = 3'h7;
            acc(MC, 0, 1, 0, 8'h00);
            acc(MC, 0, 0, 1, 8'h00);
            cmp(rd_q, 8'h07);
            $display("test bits done");
        end
    endtask
    task t_stop;
        begin
            acc(MC, 1, 0, 0, 8'h02);
            acc(SR, 1, 0, 0, 8'h5a);
            acc(MC, 1, 0, 0, 8'h82);
            repeat (20) @(negedge ref_clk_i);
            acc(SR, 0, 0, 1, 8'h00);
            cmp(rd_q, 8'h5a);
            cmp({6'h00, busy_o, sclk_pin_o}, 8'h01);
            $display("test stop done");
        end
    endtask
    task t_wires;
        begin
            for (i = 0; i < 4; i = i + 1)
                run(8'h80 | i[7:0], 1'b0, 8'h3c ^ i[7:0], 8'ha5 ^ i[7:0]);
            run(8'h86, 1'b0, 8'h00, 8'h5a);
            run(8'h82, 1'b1, 8'hc3, 8'hc3);
            run(8'h87, 1'b1, 8'h00, 8'h96);
            $display("test wires done");
        end
    endtask
    initial begin
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1;
        t_reset;
        t_bits;
        t_stop;
        t_wires;
        results;
    end
endmodule // testbench
